//--- rtl/psp_top.sv
// Overview of operation
// (R01) slave port only while mode bit set
// (R02) external side accessed without device clock
// (R03) control pins become read, write, select
// (R04) two latches share one register address
// (R05) data direction register ignored in mode
// (R06) inbound full set by write, cleared
// (R07) outbound full set by cpu, cleared
// (R08) write while full flags overrun, keeps
// (R09) outside mode full flags forced zero
// (R10) event flag per access, masked output
// (R11) low read with select drives latch
// (R12) low write with select captures data
// (R13) select high ignores strobes, no drive
// (R14) strobes synchronised, trailing edges counted
`timescale 1ns/1ps
`default_nettype none

module psp_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  pd_i,
	output logic      [7:0]  pd_o,
	output logic      [7:0]  pd_oe_o,
	input  wire logic [2:0]  re_i,
	output logic      [2:0]  re_o,
	output logic      [2:0]  re_oe_o,
	output logic             event_irq_o
);

	////////////////////////////////////////////////////////////////////
	// state

	logic                  ack_q;
	logic [31:0]           dat_q;
	logic [7:0]            in_latch_q;
	logic [7:0]            out_latch_q;
	logic                  ibf_q;
	logic                  obf_q;
	logic                  ovf_q;
	logic                  mode_q;
	logic [2:0]            re_dir_q;
	logic [2:0]            re_lat_q;
	logic                  evt_flag_q;
	logic                  evt_en_q;
	logic [2:0]            ana_cfg_q;
	logic [7:0]            pd_dir_q;
	psp_pkg::psp_strobe_t  strb1_q;
	psp_pkg::psp_strobe_t  strb2_q;
	psp_pkg::psp_strobe_t  strb3_q;
	logic [7:0]            pd1_q;
	logic [7:0]            pd2_q;
	logic [7:0]            wr_byte_q;

	////////////////////////////////////////////////////////////////////
	// bus decode

	wire        req;
	wire        bus_do;
	wire        wr_do;
	wire        rd_do;
	wire [7:0]  idx;
	wire        hit_latch;
	wire        hit_strb;
	wire        hit_flags;
	wire        hit_pddir;
	wire        hit_status;
	wire        hit_enables;
	wire        hit_analog;
	wire [7:0]  wbyte;
	wire [7:0]  status_rd;
	wire [7:0]  latch_rd;
	wire [7:0]  rd_mux;

	assign req         = wb_cyc_i && wb_stb_i;
	assign bus_do      = req && ack_q;
	assign wr_do       = bus_do && wb_we_i && wb_sel_i[0];
	assign rd_do       = bus_do && !wb_we_i;
	assign idx         = wb_adr_i[9:2];
	assign hit_latch   = (idx == psp_pkg::IDX_LATCH);
	assign hit_strb    = (idx == psp_pkg::IDX_STRB);
	assign hit_flags   = (idx == psp_pkg::IDX_FLAGS);
	assign hit_pddir   = (idx == psp_pkg::IDX_PDDIR);
	assign hit_status  = (idx == psp_pkg::IDX_STATUS);
	assign hit_enables = (idx == psp_pkg::IDX_ENABLES);
	assign hit_analog  = (idx == psp_pkg::IDX_ANALOG);
	assign wbyte       = wb_dat_i[7:0];

	assign status_rd = {ibf_q, obf_q, ovf_q, mode_q, 1'b0, re_dir_q};
	// in slave mode the cpu sees the inbound latch, else the pins
	assign latch_rd  = mode_q ? in_latch_q : pd_i; // R04

	assign rd_mux =
		hit_latch   ? latch_rd :
		hit_strb    ? {5'h00, re_i} :
		hit_flags   ? {evt_flag_q, 7'h00} :
		hit_pddir   ? pd_dir_q :
		hit_status  ? status_rd :
		hit_enables ? {evt_en_q, 7'h00} :
		hit_analog  ? {5'h00, ana_cfg_q} :
		8'h00;

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// one wait state; ack drops the cycle after it was given
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req && !ack_q;
			if (req && !ack_q)
				dat_q <= {24'h00_0000, rd_mux};
		end
	end

	////////////////////////////////////////////////////////////////////
	// external strobe synchronisers

	wire rd_act2;
	wire rd_act3;
	wire wr_act2;
	wire wr_act3;
	wire rd_end;
	wire wr_end;
	wire ext_rd_now;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			strb1_q <= psp_pkg::STROBE_IDLE;
			strb2_q <= psp_pkg::STROBE_IDLE;
			strb3_q <= psp_pkg::STROBE_IDLE;
		end
		else
		begin
			strb1_q <= {re_i[psp_pkg::PIN_CS], re_i[psp_pkg::PIN_WR],
				re_i[psp_pkg::PIN_RD]}; // R03 R14
			strb2_q <= strb1_q; // R02
			strb3_q <= strb2_q;
		end
	end

	// data pins follow the same two-stage delay as the strobes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pd1_q <= 8'h00;
			pd2_q <= 8'h00;
		end
		else
		begin
			pd1_q <= pd_i;
			pd2_q <= pd1_q;
		end
	end

	assign rd_act2 = !strb2_q.cs_n && !strb2_q.rd_n; // R11 R13
	assign rd_act3 = !strb3_q.cs_n && !strb3_q.rd_n;
	assign wr_act2 = !strb2_q.cs_n && !strb2_q.wr_n; // R12 R13
	assign wr_act3 = !strb3_q.cs_n && !strb3_q.wr_n;
	assign rd_end  = mode_q && rd_act3 && !rd_act2; // R14 R01
	assign wr_end  = mode_q && wr_act3 && !wr_act2; // R14 R01

	// last byte seen while the write strobe was active
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wr_byte_q <= 8'h00;
		else if (wr_act2)
			wr_byte_q <= pd2_q; // R12
	end

	////////////////////////////////////////////////////////////////////
	// inbound byte buffer

	wire       fifo_rdy;
	wire       fifo_vld;
	wire [7:0] fifo_dat;
	wire       drain_ok;
	wire       pop;
	wire       drop;

	// hold the drain while the cpu touches the latch
	assign drain_ok = !(req && hit_latch);
	assign pop      = fifo_vld && drain_ok;
	assign drop     = wr_end && !fifo_rdy;

	psp_fifo #(
		.WIDTH (8),
		.DEPTH (psp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (wr_end),
		.in_ready_o  (fifo_rdy),
		.in_data_i   (wr_byte_q),
		.out_valid_o (fifo_vld),
		.out_ready_i (drain_ok),
		.out_data_o  (fifo_dat)
	);

	////////////////////////////////////////////////////////////////////
	// latches and slave flags

	wire ibf_d;
	wire obf_d;
	wire ovf_d;
	wire evt_d;

	assign ibf_d =
		!mode_q                       ? 1'b0 : // R09
		(pop && !ibf_q)               ? 1'b1 : // R06
		(rd_do && hit_latch)          ? 1'b0 : // R06
		ibf_q;

	// set wins over the clear
	assign obf_d =
		!mode_q                       ? 1'b0 : // R09
		(wr_do && hit_latch)          ? 1'b1 : // R07
		rd_end                        ? 1'b0 : // R07
		obf_q;

	assign ovf_d =
		((pop && ibf_q) || drop)      ? 1'b1 : // R08
		(wr_do && hit_status)         ? wbyte[psp_pkg::STAT_OVF] : // R09
		ovf_q;

	assign evt_d =
		(rd_end || wr_end)            ? 1'b1 : // R10
		(wr_do && hit_flags)          ? wbyte[psp_pkg::EVT_BIT] :
		evt_flag_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ibf_q      <= psp_pkg::RST_STATUS[psp_pkg::STAT_IBF];
			obf_q      <= psp_pkg::RST_STATUS[psp_pkg::STAT_OBF];
			ovf_q      <= psp_pkg::RST_STATUS[psp_pkg::STAT_OVF];
			evt_flag_q <= psp_pkg::RST_FLAGS[psp_pkg::EVT_BIT];
		end
		else
		begin
			ibf_q      <= ibf_d;
			obf_q      <= obf_d;
			ovf_q      <= ovf_d;
			evt_flag_q <= evt_d;
		end
	end

	// an overrun keeps the byte already held
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			in_latch_q <= psp_pkg::RST_LATCH;
		else if (pop && !ibf_q)
			in_latch_q <= fifo_dat; // R04 R08
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			out_latch_q <= psp_pkg::RST_LATCH;
		else if (wr_do && hit_latch)
			out_latch_q <= wbyte; // R04
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_q   <= psp_pkg::RST_STATUS[psp_pkg::STAT_MODE];
			re_dir_q <= psp_pkg::RST_STATUS[psp_pkg::STAT_DIRW-1:0];
		end
		else if (wr_do && hit_status)
		begin
			mode_q   <= wbyte[psp_pkg::STAT_MODE]; // R01
			re_dir_q <= wbyte[psp_pkg::STAT_DIRW-1:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			re_lat_q  <= 3'h0;
			evt_en_q  <= psp_pkg::RST_ENABLES[psp_pkg::EVT_BIT];
			ana_cfg_q <= psp_pkg::RST_ANALOG[psp_pkg::ANA_W-1:0];
			pd_dir_q  <= psp_pkg::RST_PDDIR;
		end
		else
		begin
			if (wr_do && hit_strb)
				re_lat_q <= wbyte[2:0];
			if (wr_do && hit_enables)
				evt_en_q <= wbyte[psp_pkg::EVT_BIT];
			if (wr_do && hit_analog)
				ana_cfg_q <= wbyte[psp_pkg::ANA_W-1:0];
			if (wr_do && hit_pddir)
				pd_dir_q <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pins

	// raw pins decide the drive window, so the bus sees no lag
	assign ext_rd_now = !re_i[psp_pkg::PIN_CS]
		&& !re_i[psp_pkg::PIN_RD]; // R11 R13 R02

	assign pd_o    = out_latch_q; // R11
	assign pd_oe_o = mode_q ? {8{ext_rd_now}} : ~pd_dir_q; // R05
	assign re_o    = re_lat_q;
	// in slave mode the control pins are inputs only
	assign re_oe_o = mode_q ? 3'h0 : ~re_dir_q; // R03
	assign event_irq_o = evt_flag_q && evt_en_q; // R10

endmodule : psp_top

`default_nettype wire

//--- include/psp_pkg.sv
`default_nettype none

package psp_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_LATCH   = 8'h08;
	localparam logic [7:0] IDX_STRB    = 8'h09;
	localparam logic [7:0] IDX_FLAGS   = 8'h0c;
	localparam logic [7:0] IDX_PDDIR   = 8'h88;
	localparam logic [7:0] IDX_STATUS  = 8'h89;
	localparam logic [7:0] IDX_ENABLES = 8'h8c;
	localparam logic [7:0] IDX_ANALOG  = 8'h9f;

	// status register fields
	localparam int unsigned STAT_IBF  = 7;
	localparam int unsigned STAT_OBF  = 6;
	localparam int unsigned STAT_OVF  = 5;
	localparam int unsigned STAT_MODE = 4;
	localparam int unsigned STAT_DIRW = 3;

	// event flag and enable position
	localparam int unsigned EVT_BIT = 7;

	// control pin positions and analog config width
	localparam int unsigned PIN_RD = 0;
	localparam int unsigned PIN_WR = 1;
	localparam int unsigned PIN_CS = 2;
	localparam int unsigned ANA_W  = 3;

	// reset values
	localparam logic [7:0] RST_STATUS  = 8'h07;
	localparam logic [7:0] RST_FLAGS   = 8'h00;
	localparam logic [7:0] RST_ENABLES = 8'h00;
	localparam logic [7:0] RST_ANALOG  = 8'h00;
	localparam logic [7:0] RST_PDDIR   = 8'hff;
	localparam logic [7:0] RST_LATCH   = 8'h00;

	// inbound byte buffer depth
	localparam int unsigned FIFO_DEPTH = 4;

	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} psp_strobe_t;

	localparam psp_strobe_t STROBE_IDLE = '{1'b1, 1'b1, 1'b1};

endpackage : psp_pkg

`default_nettype wire

//--- rtl/psp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module psp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      cnt_q;
	logic             out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	wire              push;
	wire              load;
	wire  [AW-1:0]    wptr_nx;
	wire  [AW-1:0]    rptr_nx;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign push        = in_valid_i && in_ready_o;
	assign load        = (cnt_q != '0) && (!out_valid_q || out_ready_i);
	assign wptr_nx     = (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
	assign rptr_nx     = (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
	assign out_valid_o = out_valid_q;
	assign out_data_o  = out_data_q;

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_q[wptr_q] <= in_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end
		else
		begin
			if (push)
				wptr_q <= wptr_nx;
			if (load)
				rptr_q <= rptr_nx;
			if (push && !load)
				cnt_q <= cnt_q + 1'b1;
			else if (load && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// registered head word
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end
		else if (load)
		begin
			out_valid_q <= 1'b1;
			out_data_q  <= mem_q[rptr_q];
		end
		else if (out_ready_i)
			out_valid_q <= 1'b0;
	end

endmodule : psp_fifo

`default_nettype wire

//--- tb/psp_ext_model.sv
`timescale 1ns/1ps
`default_nettype none

module psp_ext_model (
	input  wire logic                 clk_i,
	input  wire logic [7:0]           pin_i,
	output logic      [7:0]           dat_o,
	output psp_pkg::psp_strobe_t      strb_o
);

	initial
	begin
		strb_o = psp_pkg::STROBE_IDLE;
		dat_o  = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// one access: strobes low 4 cycles, then 8 idle
	task automatic pulse(input logic [2:0] s, input logic [7:0] d,
		output logic [7:0] q);
		strb_o <= s;
		dat_o  <= d;
		repeat (4) @(posedge clk_i);
		q = pin_i;
		strb_o <= psp_pkg::STROBE_IDLE;
		dat_o  <= ~d;
		repeat (8) @(posedge clk_i);
	endtask : pulse

endmodule : psp_ext_model

`default_nettype wire

//--- tb/psp_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module psp_top_chk (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic [7:0]  pd_o,
	input  wire logic [7:0]  pd_oe_o,
	input  wire logic [2:0]  re_i,
	input  wire logic [2:0]  re_oe_o,
	input  wire logic        event_irq_o
);

	logic       mode_q;
	logic       en_q;
	wire        reg_wr = wb_ack_o & wb_we_i & wb_sel_i[0];
	wire  [7:0] idx    = wb_adr_i[9:2];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_q <= 1'b0;
			en_q   <= 1'b0;
		end
		else if (reg_wr && idx == psp_pkg::IDX_STATUS)
			mode_q <= wb_dat_i[psp_pkg::STAT_MODE];
		else if (reg_wr && idx == psp_pkg::IDX_ENABLES)
			en_q <= wb_dat_i[psp_pkg::EVT_BIT];
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence acc_end_s;
		mode_q && !$past(re_i[2]) && ($rose(re_i[0]) || $rose(re_i[1]));
	endsequence

	ack_answer_a: assert property (
		req_s |=> wb_ack_o && wb_dat_o[31:8] == 24'h00_0000)
		else $error("no ack one cycle after request");
	ack_single_a: assert property (
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	latch_out_a: assert property (
		reg_wr && idx == psp_pkg::IDX_LATCH |=> pd_o == $past(wb_dat_i[7:0]))
		else $error("outbound latch not on data pins");
	strobe_in_a: assert property (
		mode_q |-> re_oe_o == 3'b000) else $error("control pin driven");
	read_drive_a: assert property (
		mode_q && !re_i[2] && !re_i[0] |-> pd_oe_o == 8'hff)
		else $error("read not driven");
	sel_quiet_a: assert property (
		mode_q && re_i[2] |-> pd_oe_o == 8'h00) else $error("driven unselected");
	no_read_a: assert property (
		mode_q && re_i[0] |-> pd_oe_o == 8'h00) else $error("driven without read");
	event_set_a: assert property (
		acc_end_s ##0 en_q |-> ##[1:8] event_irq_o) else $error("no event");
	irq_mask_a: assert property (
		!en_q |-> !event_irq_o) else $error("masked event raised");

endmodule : psp_top_chk

bind psp_top psp_top_chk psp_top_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pd_o(pd_o),
	.pd_oe_o(pd_oe_o), .re_i(re_i), .re_oe_o(re_oe_o),
	.event_irq_o(event_irq_o));

`default_nettype wire

//--- tb/psp_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module psp_top_tb_top;

	logic        clk_i  = 1'b0;
	logic        rst_i  = 1'b1;
	logic        cyc    = 1'b0;
	logic        stb    = 1'b0;
	logic        we     = 1'b0;
	logic [9:0]  adr    = 10'h000;
	logic [31:0] wdat   = 32'h0000_0000;
	wire  [31:0] rdat;
	wire         ack;
	wire         irq;
	wire  [7:0]  pd_o;
	wire  [7:0]  pd_oe;
	wire  [7:0]  ext_d;
	wire  [7:0]  pin;
	wire  [2:0]  re_o;
	wire  [2:0]  re_oe;
	wire  [2:0]  strb;
	wire  [2:0]  re_pin;
	int          n_fail = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [7:0]  q;

	assign pin    = (pd_oe & pd_o) | (~pd_oe & ext_d);
	assign re_pin = (re_oe & re_o) | (~re_oe & strb);

	psp_top psp_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pd_i(pin),
		.pd_o(pd_o), .pd_oe_o(pd_oe), .re_i(re_pin), .re_o(re_o),
		.re_oe_o(re_oe), .event_irq_o(irq));
	psp_ext_model psp_ext_model_i (.clk_i(clk_i), .pin_i(pin),
		.dat_o(ext_d), .strb_o(strb));

	always #2 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			results();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] r);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {a, 2'b00};
		wdat <= {24'h00_0000, d};
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		wb(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		wb(1'b0, a, 8'h00, r);
		chk(r, e);
	endtask : rd

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(psp_pkg::IDX_STATUS, 8'h07);
		rd(8'h10, 8'h00);
		wr(psp_pkg::IDX_STRB, 8'h05);
		chk({5'h00, re_o}, 8'h05);
		rd(psp_pkg::IDX_STRB, 8'h07);
		psp_ext_model_i.pulse(3'b001, 8'h42, q);
		rd(psp_pkg::IDX_FLAGS, 8'h00);
		rd(psp_pkg::IDX_STATUS, 8'h07);
		$display("test reset done");
	endtask : t_reset

	task automatic t_out;
		wr(psp_pkg::IDX_STATUS, 8'h17);
		wr(psp_pkg::IDX_ENABLES, 8'h80);
		wr(8'h88, 8'h00);
		chk(pd_oe, 8'h00);
		chk({5'h00, re_oe}, 8'h00);
		wr(psp_pkg::IDX_LATCH, 8'ha5);
		rd(psp_pkg::IDX_STATUS, 8'h57);
		psp_ext_model_i.pulse(3'b010, 8'h00, q);
		chk(q, 8'ha5);
		rd(psp_pkg::IDX_STATUS, 8'h17);
		rd(psp_pkg::IDX_FLAGS, 8'h80);
		chk({7'h00, irq}, 8'h01);
		wr(psp_pkg::IDX_FLAGS, 8'h00);
		chk({7'h00, irq}, 8'h00);
		$display("test outbound done");
	endtask : t_out

	task automatic t_in;
		psp_ext_model_i.pulse(3'b001, 8'h3c, q);
		rd(psp_pkg::IDX_STATUS, 8'h97);
		rd(psp_pkg::IDX_LATCH, 8'h3c);
		rd(psp_pkg::IDX_STATUS, 8'h17);
		psp_ext_model_i.pulse(3'b001, 8'h11, q);
		psp_ext_model_i.pulse(3'b001, 8'h22, q);
		rd(psp_pkg::IDX_STATUS, 8'hb7);
		rd(psp_pkg::IDX_LATCH, 8'h11);
		wr(psp_pkg::IDX_FLAGS, 8'h00);
		psp_ext_model_i.pulse(3'b100, 8'h77, q);
		chk(q, 8'h77);
		rd(psp_pkg::IDX_FLAGS, 8'h00);
		rd(psp_pkg::IDX_STATUS, 8'h37);
		$display("test inbound done");
	endtask : t_in

	task automatic t_leave;
		wr(psp_pkg::IDX_LATCH, 8'h5a);
		psp_ext_model_i.pulse(3'b001, 8'h66, q);
		rd(psp_pkg::IDX_STATUS, 8'hf7);
		wr(8'h88, 8'hff);
		// leave slave mode, writing the overrun bit back as set
		wr(psp_pkg::IDX_STATUS, 8'h27);
		rd(psp_pkg::IDX_STATUS, 8'h27);
		rd(psp_pkg::IDX_LATCH, 8'h99);
		wr(psp_pkg::IDX_STATUS, 8'h07);
		rd(psp_pkg::IDX_STATUS, 8'h07);
		// control pins set as outputs: released only in slave mode
		wr(psp_pkg::IDX_STATUS, 8'h10);
		chk({5'h00, re_oe}, 8'h00);
		wr(psp_pkg::IDX_STATUS, 8'h00);
		chk({5'h00, re_oe}, 8'h07);
		$display("test leave done");
	endtask : t_leave

	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_out();
		t_in();
		t_leave();
		results();
	end

endmodule : psp_top_tb_top

`default_nettype wire
